// *** src/tec_pkg.sv ***
// package: register map, field layout, reset values and types of the timer/event counter
package tec_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] TEC_MODE_ADDR    = 12'h0fa0; // counter_mode_reg
	localparam logic [11:0] TEC_MODULO_ADDR  = 12'h0fa6; // modulo_reg
	localparam logic [11:0] TEC_COUNT_ADDR   = 12'h0fa4; // count_reg, read only
	localparam logic [11:0] TEC_OE_ADDR      = 12'h0fa2; // pulse_output_enable, bit 0
	localparam logic [11:0] TEC_IRQ_ADDR     = 12'h0fa8; // match_irq_flag, bit 0

	// ****************************************
	// mode register fields
	// ****************************************
	localparam int          TEC_EN_BIT       = 2;
	localparam int          TEC_START_BIT    = 3;
	localparam int          TEC_SEL_LSB      = 4;
	localparam logic [7:0]  TEC_MODE_MASK    = 8'h0074; // bits that store; bit 3 self-clears
	localparam logic [7:0]  TEC_MODE_RESET   = 8'h0000;
	localparam logic [7:0]  TEC_MODULO_RESET = 8'h0000;
	localparam logic [7:0]  TEC_COUNT_RESET  = 8'h0000;

	// ****************************************
	// prescaler taps (top bit index, log2 of the division minus one)
	// ****************************************
	localparam int          TEC_DIV_W        = 10;
	localparam int          TEC_TAP_1024     = 9;
	localparam int          TEC_TAP_256      = 7;
	localparam int          TEC_TAP_64       = 5;
	localparam int          TEC_TAP_16       = 3;

	// count pulse selector codes
	typedef enum logic [2:0] {
		TEC_SEL_RISE = 3'b000,
		TEC_SEL_FALL = 3'b001,
		TEC_SEL_1024 = 3'b100,
		TEC_SEL_256  = 3'b101,
		TEC_SEL_64   = 3'b110,
		TEC_SEL_16   = 3'b111
	} tec_sel_t;

	// cpu-side access to the register space
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        bit_wr;  // single-bit write
		logic [2:0]  bit_idx;
		logic        bit_val;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} tec_req_t;

endpackage : tec_pkg

// *** src/tec_prescaler.sv ***
// free-running fx divider producing one-cycle ticks at the four count rates
module tec_prescaler
	import tec_pkg::*;
#(
	parameter int DIV_W = TEC_DIV_W
) (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	output logic      [3:0] tick_o   // 0:fx/1024 1:fx/256 2:fx/64 3:fx/16
);

	logic [DIV_W-1:0] div;
	logic [DIV_W-1:0] next_div;

	assign next_div = div + {{(DIV_W-1){1'b0}}, 1'b1};

	// ****************************************
	// divider
	// ****************************************
	// runs freely so the timer phase does not depend on when counting is enabled
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			div <= '0;
		end else begin
			div <= next_div;
		end
	end

	// a tick marks the cycle in which the low tap bits are all ones, just before they wrap to zero
	assign tick_o[0] = &div[TEC_TAP_1024:0];
	assign tick_o[1] = &div[TEC_TAP_256:0];
	assign tick_o[2] = &div[TEC_TAP_64:0];
	assign tick_o[3] = &div[TEC_TAP_16:0];

endmodule : tec_prescaler

// *** src/tec_timer.sv ***
// timer/event counter channel: mode, modulo, count, output flop and match flag
// Operation
// - mode bit 3 is start, bit-writable, clears itself when counting begins
// - start write clears count and flag; counting needs enable bit 2 set
// - any write setting start resets the output toggle flop
// - reset clears mode register, output enable and output toggle flop
// - output enable gates the toggle flop state onto the pulse pin
// - enable bit 0 blocks count pulses, count holds
// - enable bit 1 feeds the pulse picked by mode bits 4 to 6
// - selector: rise, fall, fx/1024, fx/256, fx/64, fx/16; others prohibited
// - count equal to modulo inverts toggle flop and clears count
// - match interval is modulo plus one count pulse periods
// - pin test, pin drive, modulo write, count read, flag access always work
// - count readable as 8 bits anytime; event pin divided by n to pin
// - toggle flop also supplies the serial shift clock
module tec_timer
	import tec_pkg::*;
(
	input  wire logic            clock_i,
	input  wire logic            rst_i,
	input  wire tec_pkg::tec_req_t req_i,
	output logic           [7:0] rdata_o,
	input  wire logic            event_input_pin_i,
	output logic                 pulse_output_pin_o,
	output logic                 pulse_output_pin_oe_o,
	output logic                 serial_shift_clock_o,
	output logic                 match_irq_flag_o,
	output logic                 match_pulse_o
);
	import tec_pkg::*;

	logic [7:0] counter_mode_reg;
	logic [7:0] modulo_reg;
	logic [7:0] count_reg;
	logic       pulse_output_enable;
	logic       output_toggle_flop;
	logic       match_irq_flag;
	logic       start_pend;
	logic [2:0] pin_sync;            // [0],[1] synchroniser, [2] previous sample
	logic [3:0] tick;
	logic [7:0] rdata;

	// ****************************************
	// access decode
	// ****************************************
	function automatic logic hit(input tec_req_t r, input logic [11:0] a);
		return r.addr == a;
	endfunction : hit

	wire        mode_wr    = req_i.wr && hit(req_i, TEC_MODE_ADDR);
	wire        mode_bwr   = req_i.bit_wr && hit(req_i, TEC_MODE_ADDR);
	wire        modulo_wr  = req_i.wr && hit(req_i, TEC_MODULO_ADDR);
	wire        oe_wr      = req_i.wr && hit(req_i, TEC_OE_ADDR);
	wire        oe_bwr     = req_i.bit_wr && hit(req_i, TEC_OE_ADDR) && req_i.bit_idx == 3'd0;
	wire        irq_wr     = req_i.wr && hit(req_i, TEC_IRQ_ADDR);
	wire        irq_bwr    = req_i.bit_wr && hit(req_i, TEC_IRQ_ADDR) && req_i.bit_idx == 3'd0;
	// byte write or single-bit write of 1 to bit 3
	wire        start_wr   = (mode_wr && req_i.wdata[TEC_START_BIT])
	                       || (mode_bwr && req_i.bit_idx == 3'(TEC_START_BIT) && req_i.bit_val);

	// next mode value: byte write, or read-modify-write of a single bit
	logic [7:0] bit_mask;
	logic [7:0] next_mode;
	assign bit_mask  = 8'h0001 << req_i.bit_idx;
	assign next_mode = mode_wr  ? (req_i.wdata & TEC_MODE_MASK)
	                 : mode_bwr ? (((counter_mode_reg & ~bit_mask)
	                               | ({8{req_i.bit_val}} & bit_mask)) & TEC_MODE_MASK)
	                 : counter_mode_reg;

	// ****************************************
	// count pulse selection
	// ****************************************
	wire        en       = counter_mode_reg[TEC_EN_BIT];
	wire  [2:0] sel      = counter_mode_reg[TEC_SEL_LSB +: 3];
	wire        pin_rise = pin_sync[1] & ~pin_sync[2];
	wire        pin_fall = ~pin_sync[1] & pin_sync[2];
	logic       cp;
	always_comb begin
		case (tec_sel_t'(sel))
			TEC_SEL_RISE: cp = pin_rise;
			TEC_SEL_FALL: cp = pin_fall;
			TEC_SEL_1024: cp = tick[0];
			TEC_SEL_256:  cp = tick[1];
			TEC_SEL_64:   cp = tick[2];
			TEC_SEL_16:   cp = tick[3];
			default:      cp = 1'b0;                                   // prohibited codes count nothing
		endcase
	end

	// a start write holds off counting for that cycle and the next so the cleared count is clean
	wire        cp_gated = en && cp && !start_wr && !start_pend;
	wire        match    = cp_gated && (count_reg == modulo_reg);

	tec_prescaler #(
		.DIV_W (TEC_DIV_W)
	) u_prescaler (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.tick_o  (tick)
	);

	// ****************************************
	// event pin synchroniser
	// ****************************************
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pin_sync <= '0;
		end else begin
			pin_sync <= {pin_sync[1:0], event_input_pin_i};
		end
	end

	// ****************************************
	// mode, modulo and output enable
	// ****************************************
	// start bit shows 1 for one cycle after the write, then clears as counting begins
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			counter_mode_reg    <= TEC_MODE_RESET;
			modulo_reg          <= TEC_MODULO_RESET;
			pulse_output_enable <= 1'b0;
			start_pend          <= 1'b0;
		end else begin
			counter_mode_reg    <= next_mode;
			start_pend          <= start_wr;
			if (modulo_wr) begin
				modulo_reg <= req_i.wdata;
			end
			if (oe_wr) begin
				pulse_output_enable <= req_i.wdata[0];
			end else if (oe_bwr) begin
				pulse_output_enable <= req_i.bit_val;
			end
		end
	end

	// ****************************************
	// count, toggle flop, match flag
	// ****************************************
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			count_reg          <= TEC_COUNT_RESET;
			output_toggle_flop <= 1'b0;
			match_irq_flag     <= 1'b0;
		end else begin
			if (start_wr || match) begin
				count_reg <= TEC_COUNT_RESET;
			end else if (cp_gated) begin
				count_reg <= count_reg + 8'h0001;
			end
			if (start_wr) begin
				output_toggle_flop <= 1'b0;
			end else if (match) begin
				output_toggle_flop <= ~output_toggle_flop;
			end
			// a match in the same cycle as a software clear wins
			if (match) begin
				match_irq_flag <= 1'b1;
			end else if (start_wr) begin
				match_irq_flag <= 1'b0;
			end else if (irq_wr) begin
				match_irq_flag <= req_i.wdata[0];
			end else if (irq_bwr) begin
				match_irq_flag <= req_i.bit_val;
			end
		end
	end

	// ****************************************
	// read mux and pins
	// ****************************************
	always_comb begin
		if (hit(req_i, TEC_MODE_ADDR)) begin
			rdata = {counter_mode_reg[7:4], start_pend, counter_mode_reg[2:0]};
		end else if (hit(req_i, TEC_MODULO_ADDR)) begin
			rdata = modulo_reg;
		end else if (hit(req_i, TEC_COUNT_ADDR)) begin
			rdata = count_reg;
		end else if (hit(req_i, TEC_OE_ADDR)) begin
			rdata = {7'd0, pulse_output_enable};
		end else if (hit(req_i, TEC_IRQ_ADDR)) begin
			rdata = {7'd0, match_irq_flag};
		end else begin
			rdata = {7'd0, pin_sync[1]};                              // pin test
		end
	end

	// read data registered on rd so data outputs come from flops
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_o <= 8'h0000;
		end else if (req_i.rd) begin
			rdata_o <= rdata;
		end
	end

	// pin level follows the flop only while enabled; otherwise pin released
	assign pulse_output_pin_o    = output_toggle_flop & pulse_output_enable;
	assign pulse_output_pin_oe_o = pulse_output_enable;
	assign serial_shift_clock_o  = output_toggle_flop;
	assign match_irq_flag_o      = match_irq_flag;
	assign match_pulse_o         = match;

endmodule : tec_timer

// *** verification/tec_event_src.sv ***
// partner model: square wave on the event pin, low while idle
module tec_event_src (
	input  wire logic       clock_i,
	input  wire logic       run_i,
	input  wire logic [7:0] half_i,
	output logic            pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int c = 0;
	initial pin_o = 1'b0;
	// change off the sampling edge so the synchroniser never sees a race
	always @(negedge clock_i) begin
		c = c + 1;
		if (!run_i) begin
			pin_o = 1'b0;
			c = 0;
		end else if (c >= half_i) begin
			pin_o = !pin_o;
			c = 0;
		end
	end
endmodule : tec_event_src

// *** verification/tec_timer_props.sv ***
// checker: port-level properties of the timer/event counter
module tec_timer_props
	import tec_pkg::*;
(
	input  wire logic            clock_i,
	input  wire logic            rst_i,
	input  wire tec_pkg::tec_req_t req_i,
	input  wire logic      [7:0] rdata_o,
	input  wire logic            event_input_pin_i,
	input  wire logic            pulse_output_pin_o,
	input  wire logic            pulse_output_pin_oe_o,
	input  wire logic            serial_shift_clock_o,
	input  wire logic            match_irq_flag_o,
	input  wire logic            match_pulse_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// start is a byte write with bit 3 or a single-bit write of 1 to bit 3
	wire mode_a = req_i.addr == TEC_MODE_ADDR;
	wire st = mode_a && ((req_i.wr && req_i.wdata[3]) ||
		(req_i.bit_wr && req_i.bit_idx == 3'd3 && req_i.bit_val));
	wire fw = req_i.addr == TEC_IRQ_ADDR && (req_i.wr || req_i.bit_wr);
	wire oe_w = req_i.wr && req_i.addr == TEC_OE_ADDR;
	wire oe_d = req_i.wdata[0];
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence s_cleared;
		!serial_shift_clock_o && !match_irq_flag_o;
	endsequence
	a_pin_gate: assert property (
		pulse_output_pin_o == (serial_shift_clock_o && pulse_output_pin_oe_o))
		else $error("pin not gated by enable");
	a_reset_clear: assert property (
		$past(rst_i) |-> s_cleared ##0 !pulse_output_pin_oe_o)
		else $error("state not cleared by reset");
	a_start_clear: assert property (
		st && !match_pulse_o |=> s_cleared) else $error("start did not clear");
	a_match_toggle: assert property (
		match_pulse_o && !st |=> serial_shift_clock_o != $past(serial_shift_clock_o))
		else $error("toggle flop did not invert");
	a_match_flag: assert property (
		match_pulse_o |=> match_irq_flag_o) else $error("flag not set by match");
	a_flag_cause: assert property (
		$rose(match_irq_flag_o) |-> $past(match_pulse_o) || $past(fw))
		else $error("flag rose without cause");
	a_flag_hold: assert property (
		match_irq_flag_o && !fw && !st |=> match_irq_flag_o) else $error("flag dropped");
	a_oe_write: assert property (
		oe_w |=> pulse_output_pin_oe_o == $past(oe_d)) else $error("enable not stored");
	a_match_gap: assert property (
		match_pulse_o |=> !match_pulse_o [*3]) else $error("matches too close");
endmodule : tec_timer_props

bind tec_timer tec_timer_props i_props (.clock_i(clock_i), .rst_i(rst_i), .req_i(req_i),
	.rdata_o(rdata_o), .event_input_pin_i(event_input_pin_i),
	.pulse_output_pin_o(pulse_output_pin_o), .pulse_output_pin_oe_o(pulse_output_pin_oe_o),
	.serial_shift_clock_o(serial_shift_clock_o), .match_irq_flag_o(match_irq_flag_o),
	.match_pulse_o(match_pulse_o));

// *** verification/tec_timer_bench.sv ***
// testbench: timer/event counter against a cycle-count model
module tec_timer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import tec_pkg::*;
	logic        clock_i = 0, rst_i = 1, run = 0;
	logic        ev, pin, oe, sclk, flag, mp;
	logic [7:0]  rd, rv, c1;
	tec_req_t    req = '0;
	int          err_count = 0, checks = 0, m = 3, oe_e = 0;
	int          sel [6] = '{4, 5, 6, 7, 0, 1};
	int          dv [6] = '{1024, 256, 64, 16, 6, 6}; // event wave: rise every 6 cycles
	logic [31:0] lf = 32'h9fbc;
	logic [11:0] ra [6] = '{TEC_MODE_ADDR, TEC_OE_ADDR, TEC_COUNT_ADDR, TEC_IRQ_ADDR,
		TEC_MODULO_ADDR, 12'h0fae};
	always #4 clock_i = ~clock_i;
	tec_timer i_dut (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .rdata_o(rd),
		.event_input_pin_i(ev), .pulse_output_pin_o(pin), .pulse_output_pin_oe_o(oe),
		.serial_shift_clock_o(sclk), .match_irq_flag_o(flag), .match_pulse_o(mp));
	tec_event_src i_src (.clock_i(clock_i), .run_i(run), .half_i(8'h03), .pin_o(ev));
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(string n, int e, logic [15:0] s);
		checks++;
		if (s !== e[15:0]) begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	// k: 0 byte write, 1 bit write (d[2:0] index, d[3] value), 2 read into rv
	task automatic acc(int k, logic [11:0] a, logic [7:0] d);
		@(negedge clock_i);
		req = '{wr: k == 0, bit_wr: k == 1, rd: k == 2, bit_idx: d[2:0], bit_val: d[3],
			addr: a, wdata: d};
		@(negedge clock_i);
		req = '0;
		rv = rd;
	endtask : acc
	// two matches after a start: toggle goes 1 then 0, spacing is the model's interval
	task automatic gap(int e);
		int c;
		c = 0;
		while (mp !== 1'b1 && c < 9000) begin @(negedge clock_i); c++; end
		@(negedge clock_i);
		chk("toggle", 1, sclk);
		chk("pin", oe_e, pin);
		chk("pin enable", oe_e, oe);
		c = 1;
		while (mp !== 1'b1 && c < 9000) begin @(negedge clock_i); c++; end
		@(negedge clock_i);
		chk("interval", e, c[15:0]);
		chk("flag", 1, flag);
		chk("toggle back", 0, sclk);
	endtask : gap
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	// longest path is a few thousand cycles per selector, so this is generous
	initial begin
		#400000;
		err_count++;
		conclude();
	end
	initial begin
		repeat (6) @(negedge clock_i);
		rst_i = 0;
		foreach (ra[i]) begin
			acc(2, ra[i], 0);
			chk("reset value", 0, rv);
		end
		$display("test reset values done");
		acc(0, TEC_MODULO_ADDR, 8'h03);
		acc(0, TEC_MODE_ADDR, 8'hff);
		acc(2, TEC_MODE_ADDR, 0);
		chk("mode", 8'h74, rv);
		for (int i = 0; i < 6; i++) begin
			lf = lfsr(lf);
			m = 1 + lf % 3;
			run = (i > 3);
			acc(0, TEC_MODULO_ADDR, m[7:0]);
			acc(0, TEC_MODE_ADDR, 8'(8'h0c | sel[i] << 4));
			gap((m + 1) * dv[i]);
			$display("test selector %0d done", sel[i]);
		end
		run = 0;
		acc(0, TEC_MODE_ADDR, 8'h70);
		acc(2, TEC_COUNT_ADDR, 0);
		c1 = rv;
		repeat (50) @(negedge clock_i);
		acc(2, TEC_COUNT_ADDR, 0);
		chk("count hold", c1, rv);
		acc(1, TEC_IRQ_ADDR, 8'h00);
		acc(2, TEC_IRQ_ADDR, 0);
		chk("flag clear", 0, rv);
		acc(1, TEC_MODE_ADDR, 8'h0b);
		acc(2, TEC_COUNT_ADDR, 0);
		chk("count start", 0, rv);
		acc(0, TEC_OE_ADDR, 8'h01);
		oe_e = 1;
		acc(0, TEC_MODE_ADDR, 8'h74);
		gap((m + 1) * 16);
		$display("test hold, clear and output done");
		conclude();
	end
endmodule : tec_timer_bench
